// ===== hdl/pmd_descriptor.sv
// Protection map descriptor table with bit index decode
`timescale 1ns/1ns
`default_nettype none
`include "pmd_map.svh"

// Functional notes
// - Byte 25Eh returns top start adder 07h
// - Byte 25Fh returns top end adder 0Eh
// - 8K groups: odd bits read, even write
// - Descriptor: type, count, first, last fields
// - Type code names standard size entry
// - Repeated sizes get separate sections
// - Start 00h is bit zero, else adder
// - Lock bits consecutive, two per 8K block, one per other block
// - Bottom-up 8K,32K,64K run,32K,8K layout
// - Types: 8K=2, 32K=3, 64K=4
// - Count 2^n, or 2^m-2 for 64K
// - Density constant m is seven here
// - Adders are 8-bit two's complement
// - End field always holds signed adder
// - Section three: 126 blocks, end FCh
module pmd_descriptor #(
  parameter logic [3:0] DENSITY_M = `PMD_DENSITY_M
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Register port
  input  wire pmd_pkg::pmd_bus_req_t bus_req,
  output logic [7:0]             rdata,
  // Decode of the selected section
  input  wire logic [2:0]        decode_sel,
  output logic [8:0]             decoded_first,
  output logic [8:0]             decoded_last,
  output logic [8:0]             decoded_blocks,
  output logic                   first_is_read_lock
);
  import pmd_pkg::*;

  // ==========================================================
  // Section table
  pmd_section_t sections [5];
  assign sections[0] = '{`PMD_TYPE_8K,  `PMD_S1_COUNT, `PMD_S1_FIRST, `PMD_S1_LAST};
  assign sections[1] = '{`PMD_TYPE_32K, `PMD_S2_COUNT, `PMD_S2_FIRST, `PMD_S2_LAST};
  assign sections[2] = '{`PMD_TYPE_64K, `PMD_S3_COUNT, `PMD_S3_FIRST, `PMD_S3_LAST};
  assign sections[3] = '{`PMD_TYPE_32K, `PMD_S4_COUNT, `PMD_S4_FIRST, `PMD_S4_LAST};
  assign sections[4] = '{`PMD_TYPE_8K,  `PMD_S5_COUNT, `PMD_S5_FIRST, `PMD_S5_LAST};

  // ==========================================================
  // Index arithmetic
  function automatic logic [8:0] adder_to_index(input logic [7:0] c, input logic is_first);
    logic [8:0] base;
    base = 9'h001 + (9'h001 << DENSITY_M);
    if (is_first && c == `PMD_ZERO_LOC) begin
      adder_to_index = 9'h000;
    end else begin
      adder_to_index = base + {c[7], c};
    end
  endfunction

  function automatic logic [8:0] block_count(input pmd_section_t s);
    if (s.sector_type == `PMD_TYPE_64K) begin
      block_count = (9'h001 << DENSITY_M) - 9'h002;
    end else begin
      block_count = 9'h001 << s.sector_count[3:0];
    end
  endfunction

  // ==========================================================
  // State
  pmd_state_t state_ff;
  pmd_state_t nxt_state;

  always_comb begin
    logic [5:0]   off;
    pmd_section_t s;
    off = 6'h00;
    s = '0;
    nxt_state = state_ff;
    off = 6'(bus_req.addr - `PMD_BASE_ADDR);
    nxt_state.rvalid = bus_req.rd;
    if (bus_req.rd) begin
      if (bus_req.addr >= `PMD_BASE_ADDR && bus_req.addr <= `PMD_LAST_ADDR && off[5:2] >= 4'h3) begin
        s = sections[off[4:2] - 3'h3];
        case (off[1:0])
          `PMD_FLD_TYPE:  nxt_state.rdata = s.sector_type;
          `PMD_FLD_COUNT: nxt_state.rdata = s.sector_count;
          `PMD_FLD_FIRST: nxt_state.rdata = s.lock_bit_first_index;
          default:        nxt_state.rdata = s.lock_bit_last_index;
        endcase
      end else begin
        nxt_state.rdata = `PMD_UNMAPPED_DATA;
      end
    end
    nxt_state.sel_section = (decode_sel > 3'h4) ? 3'h4 : decode_sel;
    s = sections[nxt_state.sel_section];
    nxt_state.decoded_first = adder_to_index(s.lock_bit_first_index, 1'b1);
    nxt_state.decoded_last = adder_to_index(s.lock_bit_last_index, 1'b0);
    nxt_state.decoded_blocks = block_count(s);
    // Odd positions read-lock only inside 8K groups
    nxt_state.first_is_read_lock = (s.sector_type == `PMD_TYPE_8K) && nxt_state.decoded_first[0];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata              = state_ff.rdata;
  assign decoded_first      = state_ff.decoded_first;
  assign decoded_last       = state_ff.decoded_last;
  assign decoded_blocks     = state_ff.decoded_blocks;
  assign first_is_read_lock = state_ff.first_is_read_lock;

endmodule
`default_nettype wire

// ===== hdl/pmd_map.svh
// Offsets, field values and layout constants of the protection map descriptor
`ifndef PMD_MAP_SVH
`define PMD_MAP_SVH

// Parameter table window covered by this block
`define PMD_BASE_ADDR      12'h240
`define PMD_LAST_ADDR      12'h25f
`define PMD_TOP_START_ADDR 12'h25e
`define PMD_TOP_END_ADDR   12'h25f

// Descriptor field positions within one section word
`define PMD_FLD_TYPE       2'h0
`define PMD_FLD_COUNT      2'h1
`define PMD_FLD_FIRST      2'h2
`define PMD_FLD_LAST       2'h3

// Sector type codes
`define PMD_TYPE_8K        8'h02
`define PMD_TYPE_32K       8'h03
`define PMD_TYPE_64K       8'h04

// Density constant and its lookup
`define PMD_DENSITY_M      4'h7
`define PMD_ZERO_LOC       8'h00

// Per-section adders and counts
`define PMD_S1_COUNT       8'h02
`define PMD_S1_FIRST       8'hff
`define PMD_S1_LAST        8'h06
`define PMD_S2_COUNT       8'h00
`define PMD_S2_FIRST       8'hfd
`define PMD_S2_LAST        8'hfd
`define PMD_S3_COUNT       8'h07
`define PMD_S3_FIRST       8'h00
`define PMD_S3_LAST        8'hfc
`define PMD_S4_COUNT       8'h00
`define PMD_S4_FIRST       8'hfe
`define PMD_S4_LAST        8'hfe
`define PMD_S5_COUNT       8'h02
`define PMD_S5_FIRST       8'h07
`define PMD_S5_LAST        8'h0e

// Unmapped read value
`define PMD_UNMAPPED_DATA  8'h00

`endif

// ===== hdl/pmd_pkg.sv
// Types of the protection map descriptor
package pmd_pkg;

  typedef struct packed {
    logic [7:0] sector_type;
    logic [7:0] sector_count;
    logic [7:0] lock_bit_first_index;
    logic [7:0] lock_bit_last_index;
  } pmd_section_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } pmd_bus_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic [8:0] decoded_first;
    logic [8:0] decoded_last;
    logic [8:0] decoded_blocks;
    logic       first_is_read_lock;
    logic [2:0] sel_section;
  } pmd_state_t;

endpackage

// ===== sim/pmd_host.sv
// Host model that reads the parameter table
`timescale 1ns/1ns
`default_nettype none
module pmd_host (
  // Clock and answer
  input  wire logic              clk,
  input  wire logic [7:0]        rdata,
  // Request
  output pmd_pkg::pmd_bus_req_t  req
);
  import pmd_pkg::*;
  initial req = '0;
  // One strobe cycle, answer taken in the next
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    req <= '{a, !w, w, d};
    @(posedge clk);
    req <= '{~a, 1'b0, 1'b0, ~d};
    @(negedge clk);
    q = rdata;
  endtask
endmodule
`default_nettype wire

// ===== sim/pmd_descriptor_checker.sv
// Assertions on the descriptor ports
`timescale 1ns/1ns
`default_nettype none
module pmd_descriptor_checker #(parameter logic [3:0] DENSITY_M = 4'h7) (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire pmd_pkg::pmd_bus_req_t bus_req,
  input wire logic [7:0]            rdata,
  input wire logic [2:0]            decode_sel,
  input wire logic [8:0]            decoded_first,
  input wire logic [8:0]            decoded_last,
  input wire logic [8:0]            decoded_blocks,
  input wire logic                  first_is_read_lock
);
  import pmd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence rd_at(logic [11:0] a); bus_req.rd && bus_req.addr == a; endsequence
  sequence sel_held(logic [2:0] k); (decode_sel == k) [*3]; endsequence
  a_top_start: assert property (rd_at(12'h25e) |=> rdata == 8'h07) else $error("bad 25e");
  a_top_end: assert property (rd_at(12'h25f) |=> rdata == 8'h0e) else $error("bad 25f");
  a_mid_end: assert property (rd_at(12'h257) |=> rdata == 8'hfc) else $error("bad 257");
  a_top_type: assert property (rd_at(12'h25c) |=> rdata == 8'h02) else $error("bad 25c");
  a_low_unmapped: assert property (bus_req.rd && bus_req.addr < 12'h240 |=> rdata == 8'h00) else $error("unmapped");
  a_data_holds: assert property (!bus_req.rd |=> $stable(rdata)) else $error("rdata moved");
  a_lock_kind: assert property (first_is_read_lock == (decoded_first[0] && decoded_blocks == 9'h004))
    else $error("lock kind");
  a_top_span: assert property (sel_held(3'h4) |-> decoded_first == 9'h088 && decoded_last == 9'h08f)
    else $error("top span");
  a_mid_span: assert property (sel_held(3'h2) |-> decoded_first == 9'h000 && decoded_blocks == 9'h07e)
    else $error("mid span");
endmodule
bind pmd_descriptor pmd_descriptor_checker #(.DENSITY_M(DENSITY_M)) chk_u (.clk(clk), .reset(reset),
  .bus_req(bus_req), .rdata(rdata), .decode_sel(decode_sel), .decoded_first(decoded_first),
  .decoded_last(decoded_last), .decoded_blocks(decoded_blocks), .first_is_read_lock(first_is_read_lock));
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the descriptor
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pmd_pkg::*;
  logic clk = 1'h0, reset = 1'h1, rl;
  logic [2:0] sel = 3'h0;
  logic [7:0] rdata, q;
  logic [8:0] f, l, b;
  logic [11:0] a;
  logic [15:0] r = 16'h5cff;
  pmd_bus_req_t req;
  int failures = 0, num_checks = 0, i, k, x;
  int tab[20] = '{2, 2, 255, 6, 3, 0, 253, 253, 4, 7, 0, 252, 3, 0, 254, 254, 2, 2, 7, 14};
  always #50 clk = ~clk;
  pmd_descriptor dut_u (.clk(clk), .reset(reset), .bus_req(req), .rdata(rdata), .decode_sel(sel),
    .decoded_first(f), .decoded_last(l), .decoded_blocks(b), .first_is_read_lock(rl));
  pmd_host host_u (.clk(clk), .rdata(rdata), .req(req));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic int adj(input int c);
    return 129 + (c > 127 ? c - 256 : c);
  endfunction
  task automatic chk(input logic [8:0] got, input int e);
    num_checks++;
    if (got !== e[8:0]) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, e[8:0]);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    host_u.xfer(1'h1, 12'h25e, 8'h55, q);
    host_u.xfer(1'h0, 12'h25e, 8'h00, q);
    chk({1'h0, q}, 7);
    for (i = 0; i < 200; i++) begin
      r = lfsr(r);
      a = 12'h230 + {6'h00, r[5:0]};
      host_u.xfer(r[6], a, r[15:8], q);
      if (!r[6]) chk({1'h0, q}, (a >= 12'h24c && a <= 12'h25f) ? tab[a - 12'h24c] : 0);
    end
    for (i = 0; i < 8; i++) begin
      @(posedge clk) sel <= i[2:0];
      repeat (3) @(posedge clk);
      @(negedge clk);
      k = 4 * (i > 4 ? 4 : i);
      x = tab[k + 2] == 0 ? 0 : adj(tab[k + 2]);
      chk(f, x);
      chk(l, adj(tab[k + 3]));
      chk(b, tab[k] == 4 ? (1 << 7) - 2 : 1 << tab[k + 1]);
      chk({8'h00, rl}, tab[k] == 2 ? x % 2 : 0);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
